// >>> asrb_register_bank.sv
// Purpose: register bank of a three-axis acceleration sensor
// Assumes: one-cycle read/write strobes from the serial front end
// Notes:   rdata is registered, valid the cycle after the read strobe
`timescale 1ns/10ps

module asrb_register_bank #(
    parameter int RESET_HOLD = 4
) (
    input  wire logic                  sys_clk,
    input  wire logic                  srst,
    input  wire asrb_pkg::asrb_access_t acc,
    input  wire asrb_pkg::asrb_sample_t sample,
    input  wire logic [7:0]            heat_value,
    input  wire logic                  ready_event,
    output logic [7:0]                 rdata,
    output asrb_pkg::asrb_config_t     cfg,
    output logic [2:0]                 self_check_onehot,
    output logic                       soft_reset_busy
);
    // config state
    logic [7:0]             range_r, range_nxt;
    logic [7:0]             bw_r, bw_nxt;
    logic [7:0]             format_r, format_nxt;
    logic [7:0]             ready_en_r, ready_en_nxt;
    logic [7:0]             routing_r, routing_nxt;
    logic [7:0]             src_r, src_nxt;
    logic [7:0]             elec_r, elec_nxt;
    logic [7:0]             self_r, self_nxt;
    logic [7:0]             guard_r, guard_nxt;
    // sample state
    logic [13:0]            live_r [3];
    logic [13:0]            live_nxt [3];
    logic [7:0]             held_hi_r [3];
    logic [7:0]             held_hi_nxt [3];
    logic [2:0]             frozen_r, frozen_nxt;
    logic [2:0]             fresh_r, fresh_nxt;
    logic                   ready_r, ready_nxt;
    logic                   junk_r, junk_nxt;
    // reset sequencing
    asrb_pkg::asrb_state_t  state_r, state_nxt;
    logic [7:0]             hold_cnt_r, hold_cnt_nxt;
    // outputs
    logic [7:0]             rdata_nxt;
    asrb_pkg::asrb_config_t cfg_nxt;
    logic [2:0]             onehot_nxt;

    logic                   wr_ok;
    logic                   soft_hit;
    logic                   cfg_reset;
    logic [2:0]             lo_hit;
    logic [2:0]             hi_hit;

    // defaults visible one edge after the last hold cycle
    localparam int          SOFT_SPAN = RESET_HOLD + 1;

    // read-strobe address decode used by the freeze and fresh-flag side effects
    function automatic logic [2:0] low_hit(input logic [5:0] a, input logic rd);
        logic [2:0] h;
        h = '0;
        for (int i = 0; i < 3; i++) begin
            h[i] = rd && (a == asrb_pkg::OFS_X_LOW + 6'(2 * i));
        end
        return h;
    endfunction

    function automatic logic [2:0] high_hit(input logic [5:0] a, input logic rd);
        logic [2:0] h;
        h = '0;
        for (int i = 0; i < 3; i++) begin
            h[i] = rd && (a == asrb_pkg::OFS_X_LOW + 6'(2 * i + 1));
        end
        return h;
    endfunction

    function automatic logic [7:0] upd(input logic [7:0] cur, input logic [7:0] d,
                                       input logic [7:0] m);
        return (cur & ~m) | (d & m);
    endfunction

    // writes below 0x0f never land; reserved bits masked
    assign wr_ok     = acc.wr && (acc.addr > asrb_pkg::OFS_RO_LAST);
    assign soft_hit  = acc.wr && (acc.addr == asrb_pkg::OFS_RESET_TRIG)
                       && (acc.wdata == asrb_pkg::RESET_CODE);
    assign cfg_reset = srst || (state_r == asrb_pkg::ST_RESETTING
                       && hold_cnt_r == 8'h00);
    assign lo_hit    = low_hit(acc.addr, acc.rd);
    assign hi_hit    = high_hit(acc.addr, acc.rd);

    always_comb begin
        range_nxt    = range_r;
        bw_nxt       = bw_r;
        format_nxt   = format_r;
        ready_en_nxt = ready_en_r;
        routing_nxt  = routing_r;
        src_nxt      = src_r;
        elec_nxt     = elec_r;
        self_nxt     = self_r;
        guard_nxt    = guard_r;
        if (wr_ok && state_r == asrb_pkg::ST_RUN) begin
            case (acc.addr)
                asrb_pkg::OFS_RANGE: begin
                    range_nxt = upd(range_r, acc.wdata, asrb_pkg::MSK_RANGE);
                end
                asrb_pkg::OFS_BW: begin
                    bw_nxt = upd(bw_r, acc.wdata, asrb_pkg::MSK_BW);
                end
                asrb_pkg::OFS_FORMAT: begin
                    format_nxt = upd(format_r, acc.wdata, asrb_pkg::MSK_FORMAT);
                end
                asrb_pkg::OFS_READY_EN: begin
                    ready_en_nxt = upd(ready_en_r, acc.wdata, asrb_pkg::MSK_READY_EN);
                end
                asrb_pkg::OFS_ROUTING: begin
                    routing_nxt = upd(routing_r, acc.wdata, asrb_pkg::MSK_ROUTING);
                end
                asrb_pkg::OFS_SRC_SEL: begin
                    src_nxt = upd(src_r, acc.wdata, asrb_pkg::MSK_SRC_SEL);
                end
                asrb_pkg::OFS_ELECTRICAL: begin
                    elec_nxt = upd(elec_r, acc.wdata, asrb_pkg::MSK_ELECTRICAL);
                end
                asrb_pkg::OFS_SELF_CHECK: begin
                    self_nxt = upd(self_r, acc.wdata, asrb_pkg::MSK_SELF_CHECK);
                end
                asrb_pkg::OFS_GUARD: begin
                    guard_nxt = upd(guard_r, acc.wdata, asrb_pkg::MSK_GUARD);
                end
                default: begin
                end
            endcase
        end
        if (cfg_reset) begin
            range_nxt    = asrb_pkg::RST_RANGE;
            bw_nxt       = asrb_pkg::RST_BW;
            format_nxt   = asrb_pkg::RST_ZERO;
            ready_en_nxt = asrb_pkg::RST_ZERO;
            routing_nxt  = asrb_pkg::RST_ZERO;
            src_nxt      = asrb_pkg::RST_ZERO;
            elec_nxt     = asrb_pkg::RST_ELECTRICAL;
            self_nxt     = asrb_pkg::RST_ZERO;
            guard_nxt    = asrb_pkg::RST_ZERO;
        end
    end

    always_ff @(posedge sys_clk) begin
        range_r    <= range_nxt;
        bw_r       <= bw_nxt;
        format_r   <= format_nxt;
        ready_en_r <= ready_en_nxt;
        routing_r  <= routing_nxt;
        src_r      <= src_nxt;
        elec_r     <= elec_nxt;
        self_r     <= self_nxt;
        guard_r    <= guard_nxt;
    end

    // soft reset sequence: hold a few cycles, then restore defaults
    always_comb begin
        state_nxt    = state_r;
        hold_cnt_nxt = hold_cnt_r;
        case (state_r)
            asrb_pkg::ST_RUN: begin
                if (soft_hit) begin
                    state_nxt    = asrb_pkg::ST_RESETTING;
                    hold_cnt_nxt = 8'(RESET_HOLD - 1);
                end
            end
            asrb_pkg::ST_RESETTING: begin
                if (hold_cnt_r == 8'h00) begin
                    state_nxt = asrb_pkg::ST_RUN;
                end else begin
                    hold_cnt_nxt = hold_cnt_r - 8'h01;
                end
            end
            default: begin
                state_nxt = asrb_pkg::ST_RUN;
            end
        endcase
        if (srst) begin
            state_nxt    = asrb_pkg::ST_RUN;
            hold_cnt_nxt = 8'h00;
        end
    end

    always_ff @(posedge sys_clk) begin
        state_r    <= state_nxt;
        hold_cnt_r <= hold_cnt_nxt;
    end

    // per-axis sample, freeze and fresh flag
    always_comb begin
        frozen_nxt = frozen_r;
        fresh_nxt  = fresh_r;
        ready_nxt  = ready_event ? 1'b1 : ready_r;
        junk_nxt   = ~junk_r;
        for (int i = 0; i < 3; i++) begin
            live_nxt[i]    = live_r[i];
            held_hi_nxt[i] = held_hi_r[i];
            if (lo_hit[i] && !format_r[asrb_pkg::BIT_LATCH_DIS]) begin
                frozen_nxt[i] = 1'b1;
            end
            if (hi_hit[i] || format_r[asrb_pkg::BIT_LATCH_DIS]) begin
                frozen_nxt[i] = 1'b0;
            end
            if (hi_hit[i]) begin
                fresh_nxt[i] = 1'b0;
            end
            if (sample.valid && sample.axis == 2'(i + 1)) begin
                live_nxt[i]  = sample.value;
                fresh_nxt[i] = 1'b1;
            end
            if (!frozen_nxt[i]) begin
                held_hi_nxt[i] = live_nxt[i][13:6];
            end
        end
        if (acc.rd && acc.addr == asrb_pkg::OFS_READY_STAT && !ready_event) begin
            ready_nxt = 1'b0;
        end
        if (srst) begin
            frozen_nxt = '0;
            fresh_nxt  = '0;
            ready_nxt  = 1'b0;
            junk_nxt   = 1'b0;
            for (int i = 0; i < 3; i++) begin
                live_nxt[i]    = '0;
                held_hi_nxt[i] = '0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        frozen_r <= frozen_nxt;
        fresh_r  <= fresh_nxt;
        ready_r  <= ready_nxt;
        junk_r   <= junk_nxt;
        for (int i = 0; i < 3; i++) begin
            live_r[i]    <= live_nxt[i];
            held_hi_r[i] <= held_hi_nxt[i];
        end
    end

    // read mux and outputs
    always_comb begin
        rdata_nxt = 8'h00;
        case (acc.addr)
            asrb_pkg::OFS_IDENTITY:   rdata_nxt = asrb_pkg::IDENTITY_VALUE;
            asrb_pkg::OFS_HEAT:       rdata_nxt = heat_value;
            asrb_pkg::OFS_READY_STAT: rdata_nxt = {ready_r, 7'h00};
            asrb_pkg::OFS_RANGE:      rdata_nxt = range_r;
            asrb_pkg::OFS_BW:         rdata_nxt = bw_r;
            asrb_pkg::OFS_FORMAT:     rdata_nxt = format_r;
            asrb_pkg::OFS_RESET_TRIG: rdata_nxt = 8'h00;
            asrb_pkg::OFS_READY_EN:   rdata_nxt = ready_en_r;
            asrb_pkg::OFS_ROUTING:    rdata_nxt = routing_r;
            asrb_pkg::OFS_SRC_SEL:    rdata_nxt = src_r;
            asrb_pkg::OFS_ELECTRICAL: rdata_nxt = elec_r;
            asrb_pkg::OFS_SELF_CHECK: rdata_nxt = self_r;
            asrb_pkg::OFS_GUARD:      rdata_nxt = guard_r;
            default: begin
                for (int i = 0; i < 3; i++) begin
                    if (acc.addr == asrb_pkg::OFS_X_LOW + 6'(2 * i)) begin
                        rdata_nxt = {live_r[i][5:0], junk_r, fresh_r[i]};
                    end
                    if (acc.addr == asrb_pkg::OFS_X_LOW + 6'(2 * i + 1)) begin
                        rdata_nxt = held_hi_r[i];
                    end
                end
            end
        endcase
        cfg_nxt.full_scale        = range_r[3:0];
        cfg_nxt.filter_bandwidth  = bw_r[4:0];
        cfg_nxt.unfiltered_select = format_r[asrb_pkg::BIT_UNFILTERED];
        cfg_nxt.latch_disable     = format_r[asrb_pkg::BIT_LATCH_DIS];
        cfg_nxt.ready_irq_en      = ready_en_r[4];
        cfg_nxt.ready_to_irq_one  = routing_r[0];
        cfg_nxt.ready_to_irq_two  = routing_r[7];
        cfg_nxt.irq_electrical    = elec_r[3:0];
        cfg_nxt.self_check_axis   = self_r[1:0];
        cfg_nxt.self_check_sign   = self_r[2];
        cfg_nxt.guard_ctrl        = guard_r[2:1];
        onehot_nxt = '0;
        for (int i = 0; i < 3; i++) begin
            onehot_nxt[i] = (self_r[1:0] == 2'(i + 1));
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata             <= 8'h00;
            cfg               <= '0;
            self_check_onehot <= 3'h0;
            soft_reset_busy   <= 1'b0;
        end else begin
            rdata             <= rdata_nxt;
            cfg               <= cfg_nxt;
            self_check_onehot <= onehot_nxt;
            soft_reset_busy   <= (state_nxt == asrb_pkg::ST_RESETTING);
        end
    end

    a_ro_discard: assert property (@(posedge sys_clk) disable iff (srst)
        acc.wr && acc.addr <= asrb_pkg::OFS_RO_LAST |=> $stable(range_r) && $stable(format_r))
        else $error("write to read-only range changed state");
    a_ident_fixed: assert property (@(posedge sys_clk) disable iff (srst)
        acc.rd && acc.addr == asrb_pkg::OFS_IDENTITY |=> rdata == asrb_pkg::IDENTITY_VALUE)
        else $error("identity read wrong");
    a_trig_zero: assert property (@(posedge sys_clk) disable iff (srst)
        acc.addr == asrb_pkg::OFS_RESET_TRIG |=> rdata == 8'h00)
        else $error("trigger register read nonzero");
    a_freeze_set: assert property (@(posedge sys_clk) disable iff (srst)
        lo_hit[0] && !format_r[asrb_pkg::BIT_LATCH_DIS] && !hi_hit[0] |=> frozen_r[0])
        else $error("x low read did not freeze");
    a_freeze_hold: assert property (@(posedge sys_clk) disable iff (srst)
        frozen_r[1] && !hi_hit[1] && !format_r[asrb_pkg::BIT_LATCH_DIS]
        |=> $stable(held_hi_r[1]))
        else $error("frozen y high changed");
    a_latch_off: assert property (@(posedge sys_clk) disable iff (srst)
        format_r[asrb_pkg::BIT_LATCH_DIS] |=> frozen_r == 3'h0)
        else $error("freeze active while disabled");
    a_fresh_clear: assert property (@(posedge sys_clk) disable iff (srst)
        hi_hit[2] && !(sample.valid && sample.axis == 2'd3)
        |=> !fresh_r[2])
        else $error("z flag not cleared by high read");
    a_fresh_set: assert property (@(posedge sys_clk) disable iff (srst)
        sample.valid && sample.axis == 2'd1 |=> fresh_r[0])
        else $error("x flag not set by sample");
    a_soft_defaults: assert property (@(posedge sys_clk) disable iff (srst)
        soft_hit && state_r == asrb_pkg::ST_RUN |-> ##SOFT_SPAN
        range_r == asrb_pkg::RST_RANGE && elec_r == asrb_pkg::RST_ELECTRICAL)
        else $error("soft reset did not restore defaults");
    a_reset_defaults: assert property (@(posedge sys_clk)
        srst |=> bw_r == asrb_pkg::RST_BW && format_r == asrb_pkg::RST_ZERO)
        else $error("reset defaults wrong");
    a_busy_write: assert property (@(posedge sys_clk) disable iff (srst)
        acc.wr && state_r == asrb_pkg::ST_RESETTING && !cfg_reset
        |=> $stable(range_r) && $stable(elec_r))
        else $error("write landed during soft reset");
    a_low_flag: assert property (@(posedge sys_clk) disable iff (srst)
        lo_hit[0] |=> rdata[0] == $past(fresh_r[0]))
        else $error("x low byte flag misplaced");
    a_ready_set: assert property (@(posedge sys_clk) disable iff (srst)
        ready_event |=> ready_r)
        else $error("ready flag not set by event");
    a_onehot_off: assert property (@(posedge sys_clk) disable iff (srst)
        self_r[1:0] == 2'h0 |=> self_check_onehot == 3'h0)
        else $error("self-test active with axis code zero");
    c_soft_reset: cover property (@(posedge sys_clk) soft_hit);
    c_locked_pair: cover property (@(posedge sys_clk)
        lo_hit[0] ##[1:20] hi_hit[0]);
    c_sample_while_frozen: cover property (@(posedge sys_clk)
        frozen_r[0] && sample.valid && sample.axis == 2'd1);
    c_z_high_read: cover property (@(posedge sys_clk)
        hi_hit[2]);
endmodule

// >>> asrb_pkg.sv
// Purpose: constants and carriers for the sensor register bank
// Assumes: byte-wide registers in a 64-location space
// Notes:   identity value is arbitrary
package asrb_pkg;
    localparam int          ADDR_W          = 6;
    localparam int          DATA_W          = 8;
    localparam int          AXES            = 3;
    localparam int          SAMPLE_W        = 14;
    localparam logic [5:0]  OFS_IDENTITY    = 6'h00;
    localparam logic [5:0]  OFS_X_LOW       = 6'h02;
    localparam logic [5:0]  OFS_HEAT        = 6'h08;
    localparam logic [5:0]  OFS_READY_STAT  = 6'h0a;
    localparam logic [5:0]  OFS_RO_LAST     = 6'h0e;
    localparam logic [5:0]  OFS_RANGE       = 6'h0f;
    localparam logic [5:0]  OFS_BW          = 6'h10;
    localparam logic [5:0]  OFS_FORMAT      = 6'h13;
    localparam logic [5:0]  OFS_RESET_TRIG  = 6'h14;
    localparam logic [5:0]  OFS_READY_EN    = 6'h17;
    localparam logic [5:0]  OFS_ROUTING     = 6'h1a;
    localparam logic [5:0]  OFS_SRC_SEL     = 6'h1e;
    localparam logic [5:0]  OFS_ELECTRICAL  = 6'h20;
    localparam logic [5:0]  OFS_SELF_CHECK  = 6'h32;
    localparam logic [5:0]  OFS_GUARD       = 6'h34;
    // writable bit masks, reserved bits dropped
    localparam logic [7:0]  MSK_RANGE       = 8'h0f;
    localparam logic [7:0]  MSK_BW          = 8'h1f;
    localparam logic [7:0]  MSK_FORMAT      = 8'hc0;
    localparam logic [7:0]  MSK_READY_EN    = 8'h10;
    localparam logic [7:0]  MSK_ROUTING     = 8'h81;
    localparam logic [7:0]  MSK_SRC_SEL     = 8'h20;
    localparam logic [7:0]  MSK_ELECTRICAL  = 8'h0f;
    localparam logic [7:0]  MSK_SELF_CHECK  = 8'h07;
    localparam logic [7:0]  MSK_GUARD       = 8'h06;
    localparam logic [7:0]  RST_RANGE       = 8'h03;
    localparam logic [7:0]  RST_BW          = 8'h0f;
    localparam logic [7:0]  RST_ELECTRICAL  = 8'h05;
    localparam logic [7:0]  RST_ZERO        = 8'h00;
    localparam logic [7:0]  RESET_CODE      = 8'hb6;
    localparam logic [7:0]  IDENTITY_VALUE  = 8'h5a;  // arbitrary value
    localparam int          BIT_UNFILTERED  = 7;
    localparam int          BIT_LATCH_DIS   = 6;
    localparam int          BIT_READY_FLAG  = 7;

    typedef struct packed {
        logic       valid;
        logic [1:0] axis;
        logic [13:0] value;
    } asrb_sample_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [5:0] addr;
        logic [7:0] wdata;
    } asrb_access_t;

    typedef struct packed {
        logic [3:0] full_scale;
        logic [4:0] filter_bandwidth;
        logic       unfiltered_select;
        logic       latch_disable;
        logic       ready_irq_en;
        logic       ready_to_irq_one;
        logic       ready_to_irq_two;
        logic [3:0] irq_electrical;
        logic [1:0] self_check_axis;
        logic       self_check_sign;
        logic [1:0] guard_ctrl;
    } asrb_config_t;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_RESETTING
    } asrb_state_t;
endpackage

// >>> asrb_host_model.sv
// Purpose: host side of the register access strobes
// Assumes: one access per call, launched just after a rising edge
// Notes:   released address and data show inverted values
`timescale 1ns/10ps
module asrb_host_model (
    input  wire logic              sys_clk,
    output asrb_pkg::asrb_access_t acc,
    input  wire logic [7:0]        rdata
);
    initial begin
        acc = '0;
    end

    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        acc <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
        @(posedge sys_clk);
        acc <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~v};
    endtask

    // read data is taken at the edge that takes the strobe
    task automatic rd(input logic [5:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        acc <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge sys_clk);
        acc <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff};
        #1 v = rdata;
    endtask
endmodule

// >>> accel_sensor_register_bank_bench.sv
// Purpose: self-checking bench for the sensor register bank
// Assumes: host model issues one access at a time
// Notes:   reserved read bits are masked before each compare
`timescale 1ns/10ps
module accel_sensor_register_bank_bench;
    logic                   sys_clk;
    logic                   srst;
    asrb_pkg::asrb_access_t acc;
    asrb_pkg::asrb_sample_t sample;
    logic [7:0]             heat_value;
    logic                   ready_event;
    logic [7:0]             rdata;
    asrb_pkg::asrb_config_t cfg;
    logic [2:0]             self_check_onehot;
    logic                   soft_reset_busy;
    logic [7:0]             d;
    int                     failures;
    int                     checks;
    logic [5:0]             ta [9];
    logic [7:0]             tm [9];
    logic [7:0]             tr [9];

    asrb_register_bank #(.RESET_HOLD(4)) uut (.sys_clk(sys_clk), .srst(srst), .acc(acc),
        .sample(sample), .heat_value(heat_value), .ready_event(ready_event), .rdata(rdata),
        .cfg(cfg), .self_check_onehot(self_check_onehot), .soft_reset_busy(soft_reset_busy));
    asrb_host_model host (.sys_clk(sys_clk), .acc(acc), .rdata(rdata));

    always #2.5 sys_clk = ~sys_clk;

    task automatic give_verdict();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
        checks++;
        if ((got & m) !== (exp & m)) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got & m, exp & m);
        end
    endtask

    task automatic send(input logic [1:0] ax, input logic [13:0] v);
        @(posedge sys_clk);
        sample <= '{valid: 1'b1, axis: ax, value: v};
        @(posedge sys_clk);
        sample <= '{valid: 1'b0, axis: 2'd0, value: ~v};
    endtask

    task automatic t_defaults();
        for (int i = 0; i < 9; i++) begin
            host.rd(ta[i], d);
            chk(d, tr[i], tm[i]);
        end
        host.rd(6'h00, d);
        chk(d, asrb_pkg::IDENTITY_VALUE, 8'hff);
        chk({4'h0, cfg.full_scale}, 8'h03, 8'hff);
        $display("test defaults done");
    endtask

    task automatic t_masks();
        for (int i = 0; i < 9; i++) host.wr(ta[i], 8'hff);
        for (int i = 0; i < 9; i++) begin
            host.rd(ta[i], d);
            chk(d, tm[i], tm[i]);
        end
        chk({cfg.ready_to_irq_two, 6'h00, cfg.ready_to_irq_one}, 8'h81, 8'hff);
        chk({4'h0, cfg.irq_electrical}, 8'h0f, 8'hff);
        chk({cfg.unfiltered_select, cfg.latch_disable, 6'h00}, 8'hc0, 8'hff);
        chk({3'h0, cfg.filter_bandwidth}, 8'h1f, 8'hff);
        chk({1'b0, cfg.ready_irq_en, cfg.guard_ctrl, 1'b0, cfg.self_check_sign,
             cfg.self_check_axis}, 8'h77, 8'hff);
        $display("test masks done");
    endtask

    task automatic t_read_only();
        for (int a = 0; a < 15; a++) host.wr(6'(a), 8'ha5);
        host.rd(6'h00, d);
        chk(d, asrb_pkg::IDENTITY_VALUE, 8'hff);
        host.rd(6'h08, d);
        chk(d, heat_value, 8'hff);
        host.rd(6'h0a, d);
        chk(d, 8'h00, 8'h80);
        host.rd(6'h3f, d);
        chk(d, 8'h00, 8'hff);
        $display("test read only done");
    endtask

    task automatic t_soft_reset();
        int n;
        host.wr(6'h14, 8'h55);
        repeat (3) @(posedge sys_clk);
        #1 chk({7'h00, soft_reset_busy}, 8'h00, 8'hff);
        host.rd(6'h0f, d);
        chk(d, 8'h0f, 8'h0f);
        host.wr(6'h14, asrb_pkg::RESET_CODE);
        #1 chk({7'h00, soft_reset_busy}, 8'h01, 8'hff);
        host.wr(6'h0f, 8'h08);
        for (n = 0; n < 20 && soft_reset_busy !== 1'b0; n++) begin
            @(posedge sys_clk);
            #1;
        end
        if (n == 20) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, soft_reset_busy, 1'b0);
            give_verdict();
        end
        host.rd(6'h14, d);
        chk(d, 8'h00, 8'hff);
        t_defaults();
        $display("test soft reset done");
    endtask

    task automatic t_self_check();
        logic [2:0] e;
        for (int c = 0; c < 4; c++) begin
            e = (c == 0) ? 3'h0 : 3'h1 << (c - 1);
            host.wr(6'h32, 8'(c + 4));
            repeat (2) @(posedge sys_clk);
            #1 chk({5'h00, self_check_onehot}, {5'h00, e}, 8'hff);
            host.rd(6'h32, d);
            chk(d, 8'(c + 4), 8'h07);
        end
        host.wr(6'h32, 8'h00);
        $display("test self check done");
    endtask

    task automatic t_samples();
        send(2'd1, 14'h2a5c);
        host.rd(6'h02, d);
        chk(d, {6'h1c, 2'b01}, 8'hfd);
        send(2'd1, 14'h1234);
        host.rd(6'h03, d);
        chk(d, 8'ha9, 8'hff);
        host.rd(6'h03, d);
        chk(d, 8'h48, 8'hff);
        host.rd(6'h02, d);
        chk(d, {6'h34, 2'b00}, 8'hfd);
        send(2'd2, 14'h3f01);
        host.rd(6'h02, d);
        send(2'd1, 14'h0ff0);
        send(2'd2, 14'h2001);
        host.rd(6'h05, d);
        chk(d, 8'h80, 8'hff);
        host.rd(6'h03, d);
        chk(d, 8'h48, 8'hff);
        host.wr(6'h13, 8'h40);
        host.rd(6'h02, d);
        send(2'd1, 14'h3333);
        host.rd(6'h03, d);
        chk(d, 8'hcc, 8'hff);
        host.wr(6'h13, 8'h00);
        host.rd(6'h04, d);
        send(2'd2, 14'h0040);
        host.rd(6'h03, d);
        chk(d, 8'hcc, 8'hff);
        host.rd(6'h05, d);
        chk(d, 8'h80, 8'hff);
        host.rd(6'h05, d);
        chk(d, 8'h01, 8'hff);
        send(2'd3, 14'h1fc0);
        host.rd(6'h07, d);
        chk(d, 8'h7f, 8'hff);
        host.rd(6'h06, d);
        chk(d, 8'h00, 8'hfd);
        $display("test samples done");
    endtask

    task automatic t_ready();
        @(posedge sys_clk);
        ready_event <= 1'b1;
        @(posedge sys_clk);
        ready_event <= 1'b0;
        host.rd(6'h0a, d);
        chk(d, 8'h80, 8'h80);
        host.rd(6'h0a, d);
        chk(d, 8'h00, 8'h80);
        $display("test ready flag done");
    endtask

    initial begin
        sys_clk = 1'b0;
        srst = 1'b1;
        sample = '0;
        heat_value = 8'h3c;
        ready_event = 1'b0;
        failures = 0;
        checks = 0;
        ta = '{6'h0f, 6'h10, 6'h13, 6'h17, 6'h1a, 6'h1e, 6'h20, 6'h32, 6'h34};
        tm = '{8'h0f, 8'h1f, 8'hc0, 8'h10, 8'h81, 8'h20, 8'h0f, 8'h07, 8'h06};
        tr = '{8'h03, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00};
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        t_defaults();
        t_masks();
        t_read_only();
        t_soft_reset();
        t_self_check();
        t_samples();
        t_ready();
        give_verdict();
    end
endmodule
